//--- rtl/dswp_pkg.sv
package dswp_pkg;
  localparam int FRAME_BITS  = 16;        // shift register width
  localparam int CODE_BITS   = 8;         // converter code width
  localparam int MODE_BITS   = 2;         // power mode width
  localparam int CNT_BITS    = 5;         // bit counter width
  localparam int MODE_MSB    = 15;        // first bit on the wire
  localparam int MODE_LSB    = 14;
  localparam int CODE_MSB    = 13;
  localparam int CODE_LSB    = 6;
  localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h0f;  // index of 16th bit
  localparam logic [CODE_BITS-1:0] CODE_RST = 8'h00; // power-on code
  localparam int CLK_HZ      = 25000000;  // host system clock
  localparam int SYNC_HIGH_NS = 50;       // least idle time, worst supply
  localparam int ABORT_LEAD_NS = 15;      // lead of abort before 16th edge
  localparam int NS_PER_S    = 1000000000;
  // least times round up to whole cycles, at least one
  localparam int SYNC_HIGH_CYC = (SYNC_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000 < 1 ? 1 :
                                 (SYNC_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SCLK_HALF_CYC = 1;       // host sclk divider half period

  typedef enum logic [1:0] {
    DSWP_MODE_NORMAL = 2'b00,             // output driven
    DSWP_MODE_PD_1K  = 2'b01,             // 1 kohm to ground
    DSWP_MODE_PD_100K = 2'b10,            // 100 kohm to ground
    DSWP_MODE_HIZ    = 2'b11              // output open
  } dswp_mode_t;
endpackage : dswp_pkg

//--- rtl/dswp_if.sv
interface dswp_if;
  logic sync_n;   // frame select, active low
  logic sclk;     // serial clock from host
  logic din;      // serial data
  modport host   (output sync_n, output sclk, output din);
  modport device (input sync_n, input sclk, input din);
endinterface : dswp_if

//--- rtl/dswp_device.sv
// Behaviour
// - frame select low frames a write
// - frame select fall arms the shift register
// - sample data on sclk falling edge
// - sixteenth edge updates code and mode
// - early frame select rise aborts frame
// - host raises abort 15 ns early; host here raises it a half sclk period, 40 ns, early
// - host idles frame select 20/50 ns
// - host sclk at most 50/20 MHz
// - frame is mode, code, don't care
// - mode 00 normal, else power-down kinds
// - power-on code and mode zero
// - power-down frame still loads its code
module dswp_device
  import dswp_pkg::*;
(
  input  wire logic             clk,        // system clock, 25 MHz
  input  wire logic             arst_n,     // async reset, active low
  dswp_if.device                link,       // serial pins
  output logic [CODE_BITS-1:0]  dac_code,   // stored converter code
  output dswp_mode_t            power_mode, // stored power mode
  output logic                  out_enabled,// output amplifier on
  output logic                  update      // pulse per new value
);
  // link domain: runs on the falling edge of the host clock
  logic [FRAME_BITS-2:0] shreg;     // first fifteen bits
  logic [CNT_BITS-1:0]   bit_cnt;   // bits taken this frame
  logic                  done;      // frame finished, wait refall
  logic [FRAME_BITS-1:0] word;      // latched complete frame
  logic                  word_tgl;  // toggles on each valid frame
  wire  [FRAME_BITS-1:0] full_word = {shreg, link.din};

  // frame select high resets the frame, so a rise is an abort
  always_ff @(negedge link.sclk or posedge link.sync_n) begin
    if (link.sync_n) begin
      bit_cnt <= '0;  // partial frame dropped
      done    <= 1'b0;  // re-armed for next fall
      shreg   <= '0;
    end else if (!done) begin
      shreg   <= full_word[FRAME_BITS-2:0];
      bit_cnt <= bit_cnt + 5'h01;
      if (bit_cnt == LAST_BIT) begin
        done <= 1'b1;
      end
    end
  end

  // word and toggle live outside the abort reset: keep the last frame
  always_ff @(negedge link.sclk or negedge arst_n) begin
    if (!arst_n) begin
      word     <= '0;
      word_tgl <= 1'b0;
    end else if (!link.sync_n && !done && bit_cnt == LAST_BIT) begin
      word     <= full_word;
      word_tgl <= ~word_tgl;
    end
  end

  // system domain: two-flop sync of the toggle, then a stable word
  logic tgl_s1;   // first stage, read only by tgl_s2
  logic tgl_s2;   // synchronised toggle
  logic tgl_s3;   // previous value for edge detect
  wire  new_word = tgl_s2 ^ tgl_s3;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= word_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  // word stays put for many link edges, so capture after sync is safe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_code   <= CODE_RST;
      power_mode <= DSWP_MODE_NORMAL;
      update     <= 1'b0;
    end else begin
      update <= new_word;
      if (new_word) begin
        dac_code   <= word[CODE_MSB:CODE_LSB];
        power_mode <= dswp_mode_t'(word[MODE_MSB:MODE_LSB]);
      end
    end
  end

  assign out_enabled = (power_mode == DSWP_MODE_NORMAL);
endmodule : dswp_device

//--- rtl/dswp_host.sv
module dswp_host
  import dswp_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC  // sclk half period in clk cycles
)(
  input  wire logic             clk,      // system clock, 25 MHz
  input  wire logic             arst_n,   // async reset, active low
  dswp_if.host                  link,     // serial pins
  input  wire logic             wr_valid, // write request
  input  wire dswp_mode_t       wr_mode,  // power mode to send
  input  wire logic [CODE_BITS-1:0] wr_code, // code to send
  input  wire logic             abort,    // cut frame short
  output logic                  wr_ready, // idle, takes request
  output logic                  wr_done   // pulse, frame ended
);
  typedef enum logic [1:0] {
    DSWP_H_IDLE = 2'b00, DSWP_H_SHIFT = 2'b01, DSWP_H_GAP = 2'b10
  } dswp_hstate_t;
  dswp_hstate_t          state;
  logic [FRAME_BITS-1:0] sreg;     // bits still to send, msb first
  logic [CNT_BITS-1:0]   bits;     // bits sent
  logic [7:0]            div;      // half period counter
  logic [7:0]            gap;      // idle time counter
  logic                  sclk_q;
  logic                  sync_q;
  wire  half = (div == 8'(HALF_CYC - 1));

  // 25 MHz clk halves to 12.5 MHz max sclk, under both limits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= DSWP_H_IDLE;
      sreg    <= '0;
      bits    <= '0;
      div     <= '0;
      gap     <= '0;
      sclk_q  <= 1'b1;  // idle high, so the first edge is a fall
      sync_q  <= 1'b1;  // no frame in reset
      wr_done <= 1'b0;
    end else begin
      wr_done <= 1'b0;
      unique case (state)
        DSWP_H_IDLE: begin
          if (wr_valid) begin
            sreg   <= {wr_mode, wr_code, 6'h00};
            sync_q <= 1'b0;
            bits   <= '0;
            div    <= '0;
            state  <= DSWP_H_SHIFT;
          end
        end
        DSWP_H_SHIFT: begin
          div <= half ? 8'h00 : div + 8'h01;
          // abort at a rising edge: the fall it replaces is a half period away
          if (abort && half && !sclk_q) begin
            sync_q <= 1'b1;
            sclk_q <= 1'b1;
            gap    <= '0;
            state  <= DSWP_H_GAP;
          end else if (half) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin  // rising edge: move to next bit
              sreg <= {sreg[FRAME_BITS-2:0], 1'b0};
              if (bits == LAST_BIT + 5'h01) begin
                sync_q <= 1'b1;
                gap    <= '0;
                state  <= DSWP_H_GAP;
                sclk_q <= 1'b1;
              end
            end else begin
              bits <= bits + 5'h01;  // falling edge samples
            end
          end
        end
        DSWP_H_GAP: begin
          gap <= gap + 8'h01;
          if (gap == 8'(SYNC_HIGH_CYC)) begin
            wr_done <= 1'b1;
            state   <= DSWP_H_IDLE;
          end
        end
        default: state <= DSWP_H_IDLE;
      endcase
    end
  end

  assign link.sclk   = sclk_q;
  assign link.sync_n = sync_q;
  assign link.din    = sreg[FRAME_BITS-1];
  assign wr_ready    = (state == DSWP_H_IDLE);
endmodule : dswp_host

//--- verification/dswp_monitor.sv
module dswp_monitor (
  input wire logic clk,    // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic sync_n, // frame select
  input wire logic sclk,   // serial clock
  input wire logic din     // serial data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sclk_q; // last sclk level
  logic [4:0] falls;  // sclk falls in this frame
  // count falls per frame; an idle frame select clears the count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b1;
      falls  <= 5'h00;
    end else begin
      sclk_q <= sclk;
      falls  <= sync_n ? 5'h00 : falls + 5'(sclk_q & ~sclk);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // clock must be high as the frame opens, else a fall is lost
  property p_open; $fell(sync_n) |-> sclk; endproperty
  a_open: assert property (p_open) else $error("frame opened with sclk low");
  property p_fall_in; $fell(sclk) |-> !sync_n; endproperty
  a_fall_in: assert property (p_fall_in) else $error("sclk fell outside frame");
  property p_din; !sync_n && $changed(din) |-> sclk; endproperty
  a_din: assert property (p_din) else $error("din moved near sampling edge");
  property p_gap; $rose(sync_n) |-> sync_n [*3]; endproperty
  a_gap: assert property (p_gap) else $error("idle gap too short");
  property p_len; $rose(sync_n) |-> falls <= 5'h10; endproperty
  a_len: assert property (p_len) else $error("frame over sixteen bits");
  property p_extra; !sync_n && falls == 5'h10 |-> !$fell(sclk); endproperty
  a_extra: assert property (p_extra) else $error("edge after last bit");
  property p_end; $rose(falls == 5'h10) |-> ##[0:3] sync_n; endproperty
  a_end: assert property (p_end) else $error("frame not closed");
  property p_idle; sync_n && $past(sync_n) |-> sclk; endproperty
  a_idle: assert property (p_idle) else $error("sclk low while idle");
endmodule // dswp_monitor

//--- verification/dac_serial_write_port_tb.sv
module dac_serial_write_port_tb;
  import dswp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk, arst_n, wr_valid, abort, wr_ready, wr_done, out_enabled, update;
  logic [CODE_BITS-1:0] wr_code, dac_code; // sent and stored codes
  dswp_mode_t           wr_mode, power_mode;
  int                   error_cnt, total_checks, upd_cnt, k;
  dswp_if link_if ();
  dswp_host i_dswp_host (.clk(clk), .arst_n(arst_n), .link(link_if), .wr_valid(wr_valid),
    .wr_mode(wr_mode), .wr_code(wr_code), .abort(abort), .wr_ready(wr_ready), .wr_done(wr_done));
  dswp_device i_dswp_device (.clk(clk), .arst_n(arst_n), .link(link_if), .dac_code(dac_code),
    .power_mode(power_mode), .out_enabled(out_enabled), .update(update));
  dswp_monitor i_dswp_monitor (.clk(clk), .arst_n(arst_n), .sync_n(link_if.sync_n),
    .sclk(link_if.sclk), .din(link_if.din));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // count device load pulses
  always @(posedge clk) if (update === 1'b1) upd_cnt++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // loads seen, output enable, mode and code in one word
  task automatic look(input int n, input dswp_mode_t m, input logic [7:0] c);
    chk({upd_cnt[4:0], out_enabled, power_mode, dac_code}, {5'(n), m == DSWP_MODE_NORMAL, m, c});
  endtask
  // one frame; cut >= 0 raises abort that many cycles in
  task automatic send(input dswp_mode_t m, input logic [7:0] c, input int cut);
    int n;
    @(negedge clk);
    chk({15'h0000, wr_ready}, 16'h0001);
    wr_valid = 1'b1;
    wr_mode = m;
    wr_code = c;
    @(negedge clk);
    wr_valid = 1'b0;
    for (n = 0; n < 300 && wr_done !== 1'b1; n++) begin
      @(negedge clk);
      if (n == cut) abort = 1'b1;
    end
    abort = 1'b0;
    if (n == 300) begin
      error_cnt++;
      tally_and_finish();
    end
    repeat (4) @(negedge clk);
  endtask
  initial begin
    arst_n = 1'b0;
    wr_valid = 1'b0;
    abort = 1'b0;
    wr_mode = DSWP_MODE_NORMAL;
    wr_code = 8'h00;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    look(0, DSWP_MODE_NORMAL, 8'h00);
    send(DSWP_MODE_NORMAL, 8'ha5, -1);
    look(1, DSWP_MODE_NORMAL, 8'ha5);
    // every power-down kind; same code a5, so the check cannot tell a kept code from a load
    for (k = 1; k < 4; k++) begin
      send(dswp_mode_t'(k), 8'ha5, -1);
      look(1 + k, dswp_mode_t'(k), 8'ha5);
    end
    send(DSWP_MODE_NORMAL, 8'h5a, 10);
    look(4, DSWP_MODE_HIZ, 8'ha5);
    send(DSWP_MODE_NORMAL, 8'hff, -1);
    look(5, DSWP_MODE_NORMAL, 8'hff);
    send(DSWP_MODE_NORMAL, 8'h81, -1);
    look(6, DSWP_MODE_NORMAL, 8'h81);
    tally_and_finish();
  end
endmodule // dac_serial_write_port_tb
